/* File: hw/iaar_pkg.sv */
// Package: shared constants and types for the integer address unit register block
// Assumes: nothing beyond a SystemVerilog compiler
package iaar_pkg;
   localparam int IAAR_DATA_W = 32;
   localparam int IAAR_ENTRIES = 32;
   localparam int IAAR_IDX_W = 5;
   localparam int IAAR_CIRC_N = 4;
   localparam logic [4:0] IAAR_RESERVED_IDX = 5'h1f;
   localparam logic [31:0] IAAR_REG_RST = 32'h0000_0000;
   // Integer unit operations
   typedef enum logic [3:0] {
      IAAR_OP_ADD = 4'h0,
      IAAR_OP_SUB = 4'h1,
      IAAR_OP_ASHR = 4'h2,
      IAAR_OP_LSHR = 4'h3,
      IAAR_OP_SHL = 4'h4,
      IAAR_OP_AND = 4'h5,
      IAAR_OP_OR = 4'h6,
      IAAR_OP_XOR = 4'h7,
      IAAR_OP_ABS = 4'h8,
      IAAR_OP_MIN = 4'h9,
      IAAR_OP_MAX = 4'ha,
      IAAR_OP_PASS = 4'hb
   } iaar_op_e;
endpackage

/* File: hw/iaar_unit_if.sv */
// Interface: request and result of one integer address unit
// Assumes: single core clock shared by both sides
`timescale 1ns/1ps
interface iaar_unit_if;
   import iaar_pkg::*;
   logic op_valid;
   iaar_op_e op;
   logic [4:0] dst;
   logic [4:0] src_a;
   logic [4:0] src_b;
   logic circ_en;
   logic mem_valid;
   logic [31:0] res;
   logic res_valid;
   logic [31:0] mem_addr;
   logic mem_addr_valid;
   modport unit (input op_valid, op, dst, src_a, src_b, circ_en, mem_valid,
                 output res, res_valid, mem_addr, mem_addr_valid);
   modport core (output op_valid, op, dst, src_a, src_b, circ_en, mem_valid,
                 input res, res_valid, mem_addr, mem_addr_valid);
endinterface

/* File: hw/iaar_unit.sv */
// Integer address unit: 32-entry register file, circular index, arithmetic
// Assumes: issue from the core module on the same clock, one op per cycle
`timescale 1ns/1ps
module iaar_unit
   import iaar_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Operation
   iaar_unit_if.unit uif,
   // Circular buffer setup writes
   input wire logic circ_wr,
   input wire logic [1:0] circ_sel,
   input wire logic [31:0] circ_len,
   input wire logic [31:0] circ_base
);
   logic [31:0] regs_r [IAAR_ENTRIES];
   logic [31:0] len_r [IAAR_CIRC_N];
   logic [31:0] base_r [IAAR_CIRC_N];
   logic [31:0] res_r, addr_r;
   logic res_v_r, addr_v_r;

   function automatic logic [31:0] rd(input logic [4:0] i);
      // Reserved entry reads as zero, never general storage
      return (i == IAAR_RESERVED_IDX) ? IAAR_REG_RST : regs_r[i];
   endfunction

   wire logic [31:0] a = rd(uif.src_a);
   wire logic [31:0] b = rd(uif.src_b);
   wire logic [4:0] sh = b[4:0];
   wire logic slt = $signed(a) < $signed(b);
   logic [31:0] alu;
   // [RL4] Integer operations
   always_comb begin
      unique case (uif.op)
         IAAR_OP_ADD: alu = a + b;
         IAAR_OP_SUB: alu = a - b;
         IAAR_OP_ASHR: alu = $unsigned($signed(a) >>> sh);
         IAAR_OP_LSHR: alu = a >> sh;
         IAAR_OP_SHL: alu = a << sh;
         IAAR_OP_AND: alu = a & b;
         IAAR_OP_OR: alu = a | b;
         IAAR_OP_XOR: alu = a ^ b;
         IAAR_OP_ABS: alu = a[31] ? (32'h0000_0000 - a) : a;
         IAAR_OP_MIN: alu = slt ? a : b;
         IAAR_OP_MAX: alu = slt ? b : a;
         default: alu = a;
      endcase
   end

   // [RL8] Circular only on index entries 0..3
   wire logic circ_hit = uif.circ_en && (uif.src_a[4:2] == 3'h0);
   wire logic [1:0] ci = uif.src_a[1:0];
   wire logic [31:0] post = a + b;
   wire logic [31:0] cb = base_r[ci];
   wire logic [31:0] cl = len_r[ci];
   // [RL12] Wrap past end or below base
   wire logic [31:0] wrapped = (post >= cb + cl) ? post - cl :
                               (post < cb) ? post + cl : post;
   wire logic [31:0] new_idx = circ_hit ? wrapped : post;
   // [RL7] Reserved entry never written
   wire logic dst_ok = uif.dst != IAAR_RESERVED_IDX;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < IAAR_ENTRIES; i++) regs_r[i] <= IAAR_REG_RST;
         for (int i = 0; i < IAAR_CIRC_N; i++) begin
            len_r[i] <= IAAR_REG_RST;
            base_r[i] <= IAAR_REG_RST;
         end
         res_r <= IAAR_REG_RST;
         addr_r <= IAAR_REG_RST;
         res_v_r <= 1'b0;
         addr_v_r <= 1'b0;
      end else begin
         res_v_r <= uif.op_valid && !uif.mem_valid;
         addr_v_r <= uif.mem_valid;
         if (circ_wr) begin
            len_r[circ_sel] <= circ_len;
            base_r[circ_sel] <= circ_base;
         end
         if (uif.op_valid && !uif.mem_valid) begin
            res_r <= alu;
            if (dst_ok) regs_r[uif.dst] <= alu;
         end
         // [RL6] Address from own register file, index post-modified
         if (uif.mem_valid) begin
            addr_r <= a;
            if (uif.src_a != IAAR_RESERVED_IDX) regs_r[uif.src_a] <= new_idx;
         end
      end
   end
   assign uif.res = res_r;
   assign uif.res_valid = res_v_r;
   assign uif.mem_addr = addr_r;
   assign uif.mem_addr_valid = addr_v_r;
endmodule // iaar_unit

/* File: hw/iaar_core.sv */
// Top: two compute-block data files, two integer address units, store port check
// Assumes: a sequencer issuing one instruction line per cycle on core_clk
// Functional notes
// [RL1] First compute block has 32 data registers, 32 bits, indexes 0-31.
// [RL2] No shadow bank; a single set of 32 entries only.
// [RL3] Second compute block has its own independent 32x32 data file.
// [RL4] Each address unit also adds, subtracts, shifts, logic, abs, min, max.
// [RL5] Both address units reach every internal memory block.
// [RL6] Each address unit owns a 32x32 file with circular-buffer registers.
// [RL7] Highest entry of each address unit file is reserved, not general.
// [RL8] Circular addressing via index entries 0-3 only, eight buffers total.
// [RL9] Both address units may access memory in one instruction line.
// [RL10] One output port per compute block per line; two stores from one block flag violation.
// [RL11] Two stores from different compute blocks in one line are accepted.
// [RL12] Circular index past end subtracts length; below base adds length.
`timescale 1ns/1ps
module iaar_core
   import iaar_pkg::*;
#(
   parameter int MEM_BLK_W = 2
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Compute block writes
   input wire logic cb_a_wr,
   input wire logic [4:0] cb_a_wr_idx,
   input wire logic [31:0] cb_a_wr_data,
   input wire logic cb_b_wr,
   input wire logic [4:0] cb_b_wr_idx,
   input wire logic [31:0] cb_b_wr_data,
   // First unit operation
   input wire logic u0_valid,
   input wire logic [3:0] u0_op,
   input wire logic [4:0] u0_dst,
   input wire logic [4:0] u0_src_a,
   input wire logic [4:0] u0_src_b,
   input wire logic u0_circ,
   input wire logic u0_mem,
   input wire logic u0_store,
   input wire logic u0_store_blk_b,
   input wire logic [4:0] u0_store_idx,
   // Second unit operation
   input wire logic u1_valid,
   input wire logic [3:0] u1_op,
   input wire logic [4:0] u1_dst,
   input wire logic [4:0] u1_src_a,
   input wire logic [4:0] u1_src_b,
   input wire logic u1_circ,
   input wire logic u1_mem,
   input wire logic u1_store,
   input wire logic u1_store_blk_b,
   input wire logic [4:0] u1_store_idx,
   // Circular setup
   input wire logic circ_wr,
   input wire logic circ_unit,
   input wire logic [1:0] circ_sel,
   input wire logic [31:0] circ_len,
   input wire logic [31:0] circ_base,
   // Results
   output logic [31:0] u0_res,
   output logic u0_res_valid,
   output logic [31:0] u1_res,
   output logic u1_res_valid,
   // Memory side
   output logic [31:0] u0_addr,
   output logic u0_addr_valid,
   output logic [MEM_BLK_W-1:0] u0_blk,
   output logic [31:0] u1_addr,
   output logic u1_addr_valid,
   output logic [MEM_BLK_W-1:0] u1_blk,
   output logic u0_st_valid,
   output logic [31:0] u0_st_data,
   output logic u1_st_valid,
   output logic [31:0] u1_st_data,
   output logic port_violation
);
   if (MEM_BLK_W < 1 || MEM_BLK_W > 8) begin : g_bad_blk_w
      $error("MEM_BLK_W out of range");
   end

   // [RL1] First compute block file
   logic [31:0] cb_a_r [IAAR_ENTRIES];
   // [RL3] Independent second compute block file
   logic [31:0] cb_b_r [IAAR_ENTRIES];

   iaar_unit_if if0();
   iaar_unit_if if1();
   assign if0.op_valid = u0_valid;
   assign if0.op = iaar_op_e'(u0_op);
   assign if0.dst = u0_dst;
   assign if0.src_a = u0_src_a;
   assign if0.src_b = u0_src_b;
   assign if0.circ_en = u0_circ;
   assign if0.mem_valid = u0_valid && u0_mem;
   assign if1.op_valid = u1_valid;
   assign if1.op = iaar_op_e'(u1_op);
   assign if1.dst = u1_dst;
   assign if1.src_a = u1_src_a;
   assign if1.src_b = u1_src_b;
   assign if1.circ_en = u1_circ;
   assign if1.mem_valid = u1_valid && u1_mem;

   iaar_unit u_unit0 (.core_clk(core_clk), .rst_b(rst_b), .uif(if0),
      .circ_wr(circ_wr && !circ_unit), .circ_sel(circ_sel),
      .circ_len(circ_len), .circ_base(circ_base));
   iaar_unit u_unit1 (.core_clk(core_clk), .rst_b(rst_b), .uif(if1),
      .circ_wr(circ_wr && circ_unit), .circ_sel(circ_sel),
      .circ_len(circ_len), .circ_base(circ_base));

   // Store request decode
   wire logic st0 = u0_valid && u0_mem && u0_store;
   wire logic st1 = u1_valid && u1_mem && u1_store;
   // [RL10] Same source block twice in one line
   wire logic clash = st0 && st1 && (u0_store_blk_b == u1_store_blk_b);
   // [RL11] Different blocks: both accepted
   wire logic st1_ok = st1 && !clash;
   wire logic [31:0] st0_d = u0_store_blk_b ? cb_b_r[u0_store_idx] : cb_a_r[u0_store_idx];
   wire logic [31:0] st1_d = u1_store_blk_b ? cb_b_r[u1_store_idx] : cb_a_r[u1_store_idx];

   // [RL2] Single bank only, no alternate set
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < IAAR_ENTRIES; i++) begin
            cb_a_r[i] <= IAAR_REG_RST;
            cb_b_r[i] <= IAAR_REG_RST;
         end
      end else begin
         if (cb_a_wr) cb_a_r[cb_a_wr_idx] <= cb_a_wr_data;
         if (cb_b_wr) cb_b_r[cb_b_wr_idx] <= cb_b_wr_data;
      end
   end

   logic st0_v_r, st1_v_r, viol_r;
   logic [31:0] st0_d_r, st1_d_r;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st0_v_r <= 1'b0;
         st1_v_r <= 1'b0;
         viol_r <= 1'b0;
         st0_d_r <= IAAR_REG_RST;
         st1_d_r <= IAAR_REG_RST;
      end else begin
         st0_v_r <= st0;
         st1_v_r <= st1_ok;
         viol_r <= clash;
         st0_d_r <= st0_d;
         st1_d_r <= st1_d;
      end
   end

   // Register results straight from the unit flops
   assign u0_res = if0.res;
   assign u0_res_valid = if0.res_valid;
   assign u1_res = if1.res;
   assign u1_res_valid = if1.res_valid;
   // [RL5] Any block selectable from the top address bits
   // [RL9] Both units drive addresses in the same line
   assign u0_addr = if0.mem_addr;
   assign u0_addr_valid = if0.mem_addr_valid;
   assign u0_blk = if0.mem_addr[31 -: MEM_BLK_W];
   assign u1_addr = if1.mem_addr;
   assign u1_addr_valid = if1.mem_addr_valid;
   assign u1_blk = if1.mem_addr[31 -: MEM_BLK_W];
   assign u0_st_valid = st0_v_r;
   assign u0_st_data = st0_d_r;
   assign u1_st_valid = st1_v_r;
   assign u1_st_data = st1_d_r;
   assign port_violation = viol_r;

   // Assertions
   property p_clash_flag;
      @(posedge core_clk) disable iff (!rst_b)
      (st0 && st1 && u0_store_blk_b == u1_store_blk_b) |=> port_violation && !u1_st_valid;
   endproperty
   a_clash_flag: assert property (p_clash_flag) else $error("store clash missed"); // [RL10]
   property p_split_ok;
      @(posedge core_clk) disable iff (!rst_b)
      (st0 && st1 && u0_store_blk_b != u1_store_blk_b) |=> u0_st_valid && u1_st_valid
         && !port_violation;
   endproperty
   a_split_ok: assert property (p_split_ok) else $error("split stores refused"); // [RL11]
   property p_dual_mem;
      @(posedge core_clk) disable iff (!rst_b)
      (u0_valid && u0_mem && u1_valid && u1_mem) |=> u0_addr_valid && u1_addr_valid;
   endproperty
   a_dual_mem: assert property (p_dual_mem) else $error("dual access lost"); // [RL9]
   property p_cb_a_store;
      @(posedge core_clk) disable iff (!rst_b)
      (cb_a_wr && cb_a_wr_idx != 5'h00) ##1 (st0 && !u0_store_blk_b
         && u0_store_idx == $past(cb_a_wr_idx) && !(cb_a_wr && cb_a_wr_idx == u0_store_idx))
         |=> u0_st_data == $past(cb_a_wr_data, 2);
   endproperty
   a_cb_a_store: assert property (p_cb_a_store) else $error("block a data wrong"); // [RL1]
   property p_add;
      @(posedge core_clk) disable iff (!rst_b)
      (u0_valid && !u0_mem && u0_op == 4'h0 && u0_src_a == 5'h1f && u0_src_b == 5'h1f)
         |=> u0_res == 32'h0000_0000 && u0_res_valid;
   endproperty
   a_add: assert property (p_add) else $error("reserved entry not zero"); // [RL7]
   property p_viol_pulse;
      @(posedge core_clk) disable iff (!rst_b)
      port_violation |-> $past(st0) && $past(st1);
   endproperty
   a_viol_pulse: assert property (p_viol_pulse) else $error("spurious violation"); // [RL10]
   property p_res_only_op;
      @(posedge core_clk) disable iff (!rst_b)
      u1_res_valid |-> $past(u1_valid) && !$past(u1_mem);
   endproperty
   a_res_only_op: assert property (p_res_only_op) else $error("spurious result"); // [RL4]
   property p_cb_b_store;
      @(posedge core_clk) disable iff (!rst_b)
      (st1 && u1_store_blk_b && !clash) |=> u1_st_valid;
   endproperty
   a_cb_b_store: assert property (p_cb_b_store) else $error("block b store lost"); // [RL3]
   c_clash: cover property (@(posedge core_clk) disable iff (!rst_b) clash);
   c_split: cover property (@(posedge core_clk) disable iff (!rst_b) st0 && st1_ok);
   c_circ: cover property (@(posedge core_clk) disable iff (!rst_b) u0_valid && u0_mem && u0_circ);
endmodule // iaar_core

/* File: verif/iaar_mem_model.sv */
// Memory model: sink for both store ports of the core
// Assumes: store pulses last one core_clk cycle with address alongside
`timescale 1ns/1ps
module iaar_mem_model (
   // Clock
   input wire logic core_clk,
   // Store ports
   input wire logic [31:0] a0,
   input wire logic s0,
   input wire logic [31:0] d0,
   input wire logic [31:0] a1,
   input wire logic s1,
   input wire logic [31:0] d1,
   // Bookkeeping
   output int st_count
);
   logic [31:0] mem [logic [31:0]];
   initial st_count = 0;
   always @(posedge core_clk) begin
      if (s0) mem[a0] = d0;
      if (s1) mem[a1] = d1;
      st_count = st_count + int'(s0) + int'(s1);
   end
endmodule // iaar_mem_model

/* File: verif/iaar_core_test.sv */
// Bench: drives both address units and data files, checks through queues
// Assumes: every result is registered one cycle after its issuing edge
`timescale 1ns/1ps
`define CMP(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module iaar_core_test;
   import iaar_pkg::*;
   typedef struct {logic v; logic [3:0] op; logic [4:0] d, a, b, si;
      logic c, m, s, sb;} iaar_req_s;
   typedef struct {iaar_req_s u [2]; logic cw, cu, aw, bw; logic [1:0] cs; logic [4:0] ai, bi;
      logic [31:0] cl, cb, ad, bd;} iaar_line_s;
   logic core_clk, rst_b;
   iaar_line_s cur, nxt;
   logic [31:0] u0_res, u1_res, u0_addr, u1_addr, u0_st_data, u1_st_data;
   logic u0_res_valid, u1_res_valid, u0_addr_valid, u1_addr_valid, u0_st_valid, u1_st_valid;
   logic port_violation;
   logic [1:0] u0_blk, u1_blk;
   logic [31:0] jm [2][32];
   logic [31:0] ma [32], mb [32], cbase [2][4], clen [2][4];
   logic [31:0] qe [9][$];
   logic [31:0] seed;
   int err_total, comparisons, cyc, n_st, st_count;

   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end

   iaar_core uut (
      .core_clk(core_clk), .rst_b(rst_b),
      .cb_a_wr(cur.aw), .cb_a_wr_idx(cur.ai), .cb_a_wr_data(cur.ad),
      .cb_b_wr(cur.bw), .cb_b_wr_idx(cur.bi), .cb_b_wr_data(cur.bd),
      .u0_valid(cur.u[0].v), .u0_op(cur.u[0].op), .u0_dst(cur.u[0].d), .u0_src_a(cur.u[0].a),
      .u0_src_b(cur.u[0].b), .u0_circ(cur.u[0].c), .u0_mem(cur.u[0].m), .u0_store(cur.u[0].s),
      .u0_store_blk_b(cur.u[0].sb), .u0_store_idx(cur.u[0].si),
      .u1_valid(cur.u[1].v), .u1_op(cur.u[1].op), .u1_dst(cur.u[1].d), .u1_src_a(cur.u[1].a),
      .u1_src_b(cur.u[1].b), .u1_circ(cur.u[1].c), .u1_mem(cur.u[1].m), .u1_store(cur.u[1].s),
      .u1_store_blk_b(cur.u[1].sb), .u1_store_idx(cur.u[1].si),
      .circ_wr(cur.cw), .circ_unit(cur.cu), .circ_sel(cur.cs), .circ_len(cur.cl),
      .circ_base(cur.cb), .u0_res(u0_res), .u0_res_valid(u0_res_valid), .u1_res(u1_res),
      .u1_res_valid(u1_res_valid), .u0_addr(u0_addr), .u0_addr_valid(u0_addr_valid),
      .u0_blk(u0_blk), .u1_addr(u1_addr), .u1_addr_valid(u1_addr_valid), .u1_blk(u1_blk),
      .u0_st_valid(u0_st_valid), .u0_st_data(u0_st_data), .u1_st_valid(u1_st_valid),
      .u1_st_data(u1_st_data), .port_violation(port_violation)
   );

   iaar_mem_model mem_m (.core_clk(core_clk), .a0(u0_addr), .s0(u0_st_valid), .d0(u0_st_data),
      .a1(u1_addr), .s1(u1_st_valid), .d1(u1_st_data), .st_count(st_count));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] f(logic [3:0] op, logic [31:0] a, logic [31:0] b);
      case (op)
         4'h0: return a + b;
         4'h1: return a - b;
         4'h2: return $signed(a) >>> b[4:0];
         4'h3: return a >> b[4:0];
         4'h4: return a << b[4:0];
         4'h5: return a & b;
         4'h6: return a | b;
         4'h7: return a ^ b;
         4'h8: return a[31] ? -a : a;
         4'h9: return ($signed(a) < $signed(b)) ? a : b;
         4'ha: return ($signed(a) > $signed(b)) ? a : b;
         default: return a;
      endcase
   endfunction

   task automatic alu(int k, logic [3:0] op, logic [4:0] d, a, b);
      logic [31:0] r;
      r = f(op, jm[k][a], jm[k][b]);
      nxt.u[k] = '{1'b1, op, d, a, b, 5'h0, 1'b0, 1'b0, 1'b0, 1'b0};
      qe[k].push_back(r);
      if (d != 5'h1f) jm[k][d] = r;
   endtask

   task automatic acc(int k, logic [4:0] a, b, logic c, s = 0, sb = 0, logic [4:0] si = 0);
      logic [31:0] n;
      n = jm[k][a] + jm[k][b];
      qe[2+k].push_back(jm[k][a]);
      qe[7+k].push_back({30'h0, jm[k][a][31:30]});
      nxt.u[k] = '{1'b1, 4'h0, 5'h0, a, b, si, c, 1'b1, s, sb};
      if (c && a < 4 && n >= cbase[k][a[1:0]] + clen[k][a[1:0]]) n = n - clen[k][a[1:0]];
      else if (c && a < 4 && n < cbase[k][a[1:0]]) n = n + clen[k][a[1:0]];
      if (a != 5'h1f) jm[k][a] = n;
   endtask

   task automatic circ(int k, logic [1:0] s, logic [31:0] b, logic [31:0] l);
      nxt.cw = 1'b1;
      nxt.cu = k[0];
      nxt.cs = s;
      nxt.cb = b;
      nxt.cl = l;
   endtask

   task automatic tick();
      logic same;
      same = nxt.u[0].s && nxt.u[1].s && nxt.u[0].sb == nxt.u[1].sb;
      // store data is the old file value; second store of a block dropped
      if (nxt.u[0].s) qe[4].push_back(nxt.u[0].sb ? mb[nxt.u[0].si] : ma[nxt.u[0].si]);
      if (nxt.u[1].s && !same) qe[5].push_back(nxt.u[1].sb ? mb[nxt.u[1].si] : ma[nxt.u[1].si]);
      if (nxt.u[0].s || nxt.u[1].s) qe[6].push_back({31'h0, same});
      n_st += int'(nxt.u[0].s) + int'(nxt.u[1].s && !same);
      if (nxt.aw) ma[nxt.ai] = nxt.ad;
      if (nxt.bw) mb[nxt.bi] = nxt.bd;
      if (nxt.cw) cbase[nxt.cu][nxt.cs] = nxt.cb;
      if (nxt.cw) clen[nxt.cu][nxt.cs] = nxt.cl;
      @(posedge core_clk);
      #2;
      cur = nxt;
      nxt = '{default: '0};
   endtask

   // Loads a value through a wrap of circular buffer 0, since no immediate path exists
   task automatic load(int k, logic [4:0] d, logic [31:0] v);
      alu(k, 4'h1, 5'h0, 5'h0, 5'h0);
      circ(k, 2'h0, 32'h1, v);
      tick();
      acc(k, 5'h0, 5'h1f, 1'b1);
      tick();
      alu(k, 4'hb, d, 5'h0, 5'h0);
      tick();
   endtask

   task automatic chk(int i, logic v, logic [31:0] g, string nm);
      logic [31:0] e;
      if (v !== 1'b1) return;
      if (qe[i].size() == 0) begin
         err_total++;
         $display("CHECK FAILED %s exp none got %h", nm, g);
         return;
      end
      e = qe[i].pop_front();
      `CMP(nm, e, g)
   endtask

   always @(posedge core_clk) begin
      #1;
      chk(0, u0_res_valid, u0_res, "u0_res");
      chk(1, u1_res_valid, u1_res, "u1_res");
      chk(2, u0_addr_valid, u0_addr, "u0_addr");
      chk(3, u1_addr_valid, u1_addr, "u1_addr");
      chk(7, u0_addr_valid, {30'h0, u0_blk}, "u0_blk");
      chk(8, u1_addr_valid, {30'h0, u1_blk}, "u1_blk");
      chk(4, u0_st_valid, u0_st_data, "u0_st");
      chk(5, u1_st_valid, u1_st_data, "u1_st");
      chk(6, u0_st_valid | u1_st_valid | port_violation,
         {31'h0, port_violation}, "viol");
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end

   task automatic close_out();
      `CMP("store_count", n_st, st_count)
      for (int i = 0; i < 9; i++) `CMP("pending", 0, qe[i].size())
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      seed = 32'd42;
      nxt = '{default: '0};
      cur = '{default: '0};
      rst_b = 1'b0;
      foreach (jm[k, i]) jm[k][i] = 32'h0;
      foreach (cbase[k, i]) cbase[k][i] = 32'h0;
      foreach (clen[k, i]) clen[k][i] = 32'h0;
      repeat (3) @(posedge core_clk);
      #2;
      rst_b = 1'b1;
      for (int k = 0; k < 2; k++)
         for (int i = 4; i < 10; i++)
            load(k, i[4:0], rnd() & 32'h3fff_ffff);
      // every operation in both units at once; entry 10 negative
      for (int op = -1; op < 12; op++) begin
         for (int k = 0; k < 2; k++)
            if (op < 0) alu(k, 4'h1, 5'd10, 5'h1f, 5'd4);
            else alu(k, op[3:0], 5'd11, (op == 2 || op == 8) ? 5'd10 : 5'd5, 5'd6);
         tick();
      end
      // writes to the reserved entry vanish; it reads as zero
      for (int j = 0; j < 3; j++) begin
         for (int k = 0; k < 2; k++) begin
            if (j == 0) alu(k, 4'h0, 5'h1f, 5'd4, 5'd5);
            else if (j == 1) alu(k, 4'hb, 5'd12, 5'h1f, 5'd5);
            else alu(k, 4'h0, 5'd12, 5'h1f, 5'h1f);
         end
         tick();
      end
      // fill both data files across all 32 entries
      for (int i = 0; i < 32; i++) begin
         {nxt.aw, nxt.ai, nxt.ad} = {1'b1, 5'(i), rnd()};
         {nxt.bw, nxt.bi, nxt.bd} = {1'b1, 5'(i), rnd()};
         tick();
      end
      // back-to-back store pairs, all block pairings
      // Same-line write at c=0 stores old data; write at c=1 is stored at c=2
      for (int c = 0; c < 4; c++) begin
         acc(0, 5'd4, 5'd5, 1'b0, 1'b1, c[0], 5'(c));
         acc(1, 5'd4, 5'd5, 1'b0, 1'b1, c[1], 5'(31 - c));
         {nxt.aw, nxt.ai, nxt.ad} = {c < 2, 5'(2 * c), rnd()};
         tick();
      end
      // every memory block from both units in one line
      for (int b = 0; b < 4; b++) begin
         for (int k = 0; k < 2; k++) load(k, 5'd13, {b[1:0], 30'h100});
         for (int k = 0; k < 2; k++) acc(k, 5'd13, 5'h1f, 1'b0);
         tick();
      end
      // wrap above end and below base; entry 5 never wraps
      for (int k = 0; k < 2; k++) begin
         circ(k, 2'h1, 32'd100, 32'd16);
         tick();
         load(k, 5'd1, 32'd110);
         load(k, 5'd14, 32'd8);
         alu(k, 4'h1, 5'd15, 5'h1f, 5'd14);
         tick();
         acc(k, 5'd1, 5'd14, 1'b1);
         tick();
         acc(k, 5'd1, 5'd15, 1'b1);
         tick();
         acc(k, 5'd1, 5'h1f, 1'b1);
         tick();
         acc(k, 5'd5, 5'd14, 1'b1);
         tick();
         acc(k, 5'd5, 5'h1f, 1'b0);
         tick();
      end
      repeat (3) tick();
      close_out();
   end
endmodule // iaar_core_test
